// *** design/timer_engine_cfg.svh ***
// Address map, field positions and timing counts of the timer engine
`ifndef TIMER_ENGINE_CFG_SVH
`define TIMER_ENGINE_CFG_SVH
`define ADDR_W 9
`define OFF_BASE 9'h000
`define OFF_PTR 9'h002
`define OFF_RESTART 9'h004
`define OFF_VALID 9'h006
`define OFF_CMD_HI 9'h008
`define OFF_CMD_LO 9'h00A
`define OFF_CNT_HI 9'h00C
`define OFF_CNT_LO 9'h00E
`define OFF_COMMAND 9'h010
`define OFF_EVENTS 9'h012
`define OFF_ENABLES 9'h014
`define OFF_CONFIG 9'h016
`define DPRAM_SEL_BIT 8
`define CMD_SOFT_RESET 16'h8001
`define CMD_SET_TIMER 16'h0851
`define CMD_RST_BIT 15
`define CMD_FLG_BIT 0
`define CMD_OPCH_MSB 11
`define CMD_OPCH_LSB 4
`define SET_TIMER_OPCH 8'h85
`define TW_VALID_BIT 31
`define TW_RESTART_BIT 30
`define TW_NUM_MSB 19
`define TW_NUM_LSB 16
`define TW_PERIOD_MSB 15
`define CFG_TIME_EN_BIT 15
`define CFG_GMASK_BIT 14
`define CFG_MULT_MSB 5
`define ALIGN_MASK 16'hFFFC
`define TICK_UNIT_CLKS 1024
`define CMD_LATENCY_CLKS 40
`define CMD_LATENCY_MAX_CLKS 120
`endif

// *** design/timer_engine_pkg.sv ***
// Types shared by both ends of the timer engine link
package timer_engine_pkg;
    typedef enum logic [2:0] {
        SC_IDLE = 3'b001,
        SC_RUN = 3'b010,
        SC_DONE = 3'b100
    } scan_e;
    typedef enum logic [3:0] {
        H_IDLE = 4'b0001,
        H_WRITE = 4'b0010,
        H_POLL = 4'b0100,
        H_WAIT = 4'b1000
    } host_e;
    typedef enum logic [2:0] {
        OP_SETUP = 3'h0,
        OP_CONFIG = 3'h1,
        OP_SET_TIMER = 3'h2,
        OP_ACK = 3'h3,
        OP_RESET = 3'h4
    } host_op_e;
    typedef struct packed {
        logic [15:0] base;
        logic [15:0] ptr;
        logic [15:0] restart;
        logic [15:0] valid;
        logic [31:0] tcmd;
        logic [31:0] tcnt;
        logic [15:0] command;
        logic [15:0] events;
        logic [15:0] enables;
        logic [15:0] cfg_w;
        logic [9:0] sub_cnt;
        logic [5:0] mult_cnt;
        logic [6:0] lat_cnt;
        logic busy;
        logic scan_pend;
        scan_e scan;
        logic [15:0] rdata;
        logic rvalid;
    } dev_state_s;
    typedef struct packed {
        host_e st;
        host_op_e op;
        logic [31:0] arg;
        logic [1:0] step;
        logic [8:0] addr;
        logic wr;
        logic rd;
        logic [15:0] wdata;
        logic done;
    } host_state_s;
endpackage

// *** design/coproc_link_if.sv ***
// Register link between the host and the timer engine
`timescale 1ns/1ps
interface coproc_link_if;
    logic [8:0] addr;
    logic wr;
    logic rd;
    logic [15:0] wdata;
    logic [15:0] rdata;
    logic rvalid;
    logic irq;
    modport device (input addr, input wr, input rd, input wdata,
                    output rdata, output rvalid, output irq);
    modport host (output addr, output wr, output rd, output wdata,
                  input rdata, input rvalid, input irq);
endinterface

// *** design/timer_table_engine.sv ***
// Timer table engine: command register, parameter words, table scan
//
// Function
// [RULE1] Soft reset 8001 reads back zero quickly
// [RULE2] Semaphore stays set until command completes
// [RULE3] Commands finish well inside 120 clocks
// [RULE4] Sixteen timers, one-shot or restart
// [RULE5] Tick is multiple of 1024 clocks
// [RULE6] Table scan yields to commands, ticks dropped
// [RULE7] Four-byte entries, ascending, from base offset
// [RULE8] Host aligns base offset to four
// [RULE9] Scan pointer owned by engine only
// [RULE10] Restart bitmap changed only by set-timer; soft reset also clears it here
// [RULE11] Valid bitmap changed only by set-timer; here one-shot expiry and soft reset also clear bits
// [RULE12] Word bit31 enable, bit30 restart
// [RULE13] Word bits 19..16 select timer
// [RULE14] Period zero means 65536 ticks
// [RULE15] Host zeroes reserved bits 29..20
// [RULE16] Tick counter increments after every scan
// [RULE17] Set-timer loads initial, scan decrements current
// [RULE18] Event bits write-one-to-clear, reset zero
// [RULE19] Interrupt needs event, enable and global mask
// [RULE20] Host writes word then 0851 command
// [RULE21] Expiry sets event, reloads or invalidates
// [RULE22] Set-timer defers scanning to next tick
// [RULE23] Host waits semaphore clear, reset excepted
// [RULE24] Scan ascends from timer zero
`timescale 1ns/1ps
`include "timer_engine_cfg.svh"
module timer_table_engine
    import timer_engine_pkg::*;
#(
    parameter int NUM_TIMERS = 16,
    parameter int DP_ENTRIES = 64
) (
    input wire logic core_clk,
    input wire logic rst,
    coproc_link_if.device bus,
    output logic scan_active,
    output logic [31:0] tick_total
);
    localparam int EW = $clog2(DP_ENTRIES);

    if (NUM_TIMERS < 1 || NUM_TIMERS > 16) begin : g_bad_timers
        $error("NUM_TIMERS must be 1 to 16");
    end
    if (DP_ENTRIES < NUM_TIMERS || DP_ENTRIES > 64 || (1 << EW) != DP_ENTRIES) begin : g_bad_dp
        $error("DP_ENTRIES must be a power of two, NUM_TIMERS to 64");
    end

    dev_state_s s;
    dev_state_s n;
    logic [15:0] init_mem [DP_ENTRIES];
    logic [15:0] cur_mem [DP_ENTRIES];
    logic we_i;
    logic we_c;
    logic [EW-1:0] widx;
    logic [15:0] wi_d;
    logic [15:0] wc_d;
    logic host_mem;
    logic tick;
    logic [3:0] tidx;
    logic [3:0] set_num;
    logic [EW-1:0] ent;
    logic [EW-1:0] hent;
    logic [15:0] cur_v;

    assign tidx = s.ptr[3:0];
    assign set_num = s.tcmd[`TW_NUM_MSB:`TW_NUM_LSB];
    assign ent = s.base[EW+1:2] + EW'(tidx); // RULE7
    assign hent = bus.addr[EW+1:2];
    assign cur_v = cur_mem[ent];

    always_comb begin
        n = s;
        n.rvalid = 1'b0;
        tick = 1'b0;
        we_i = 1'b0;
        we_c = 1'b0;
        widx = '0;
        wi_d = '0;
        wc_d = '0;
        host_mem = 1'b0;

        // Prescaler: 1024-clock units counted up to the programmed multiple
        if (s.cfg_w[`CFG_TIME_EN_BIT]) begin
            if (s.sub_cnt == 10'(`TICK_UNIT_CLKS - 1)) begin // RULE5
                n.sub_cnt = '0;
                if (s.mult_cnt == s.cfg_w[`CFG_MULT_MSB:0]) begin
                    n.mult_cnt = '0;
                    tick = 1'b1;
                end else begin
                    n.mult_cnt = s.mult_cnt + 6'h01;
                end
            end else begin
                n.sub_cnt = s.sub_cnt + 10'h001;
            end
        end else begin
            n.sub_cnt = '0;
            n.mult_cnt = '0;
        end
        // A tick that finds the scan still owed is lost, not queued
        if (tick && s.scan == SC_IDLE && !s.scan_pend) begin
            n.scan_pend = 1'b1; // RULE6
        end

        if (bus.rd) begin
            n.rvalid = 1'b1;
            if (bus.addr[`DPRAM_SEL_BIT]) begin
                n.rdata = bus.addr[1] ? cur_mem[hent] : init_mem[hent];
            end else begin
                case (bus.addr)
                    `OFF_BASE: n.rdata = s.base;
                    `OFF_PTR: n.rdata = s.ptr;
                    `OFF_RESTART: n.rdata = s.restart;
                    `OFF_VALID: n.rdata = s.valid;
                    `OFF_CMD_HI: n.rdata = s.tcmd[31:16];
                    `OFF_CMD_LO: n.rdata = s.tcmd[15:0];
                    `OFF_CNT_HI: n.rdata = s.tcnt[31:16];
                    `OFF_CNT_LO: n.rdata = s.tcnt[15:0];
                    `OFF_COMMAND: n.rdata = s.command; // RULE2
                    `OFF_EVENTS: n.rdata = s.events;
                    `OFF_ENABLES: n.rdata = s.enables;
                    `OFF_CONFIG: n.rdata = s.cfg_w;
                    default: n.rdata = '0;
                endcase
            end
        end

        if (bus.wr) begin
            if (bus.addr[`DPRAM_SEL_BIT]) begin
                host_mem = 1'b1;
                widx = hent;
                we_i = !bus.addr[1];
                we_c = bus.addr[1];
                wi_d = bus.wdata;
                wc_d = bus.wdata;
            end else begin
                case (bus.addr)
                    `OFF_BASE: n.base = bus.wdata;
                    `OFF_CMD_HI: n.tcmd[31:16] = bus.wdata;
                    `OFF_CMD_LO: n.tcmd[15:0] = bus.wdata;
                    `OFF_CNT_HI: n.tcnt[31:16] = bus.wdata;
                    `OFF_CNT_LO: n.tcnt[15:0] = bus.wdata;
                    `OFF_EVENTS: n.events = s.events & ~bus.wdata; // RULE18
                    `OFF_ENABLES: n.enables = bus.wdata;
                    `OFF_CONFIG: n.cfg_w = bus.wdata;
                    `OFF_COMMAND: begin
                        // Writes other than soft reset are dropped while busy; host must wait
                        if (!s.busy) begin
                            n.command = bus.wdata; // RULE2
                            n.busy = bus.wdata[`CMD_FLG_BIT];
                            n.lat_cnt = '0;
                        end
                    end
                    // Pointer and bitmaps ignore host writes
                    default: ; // RULE9 RULE10 RULE11
                endcase
            end
        end

        // Host memory access wins the single write port; engine waits
        if (s.busy) begin
            if (s.lat_cnt >= 7'(`CMD_LATENCY_CLKS - 1) && !host_mem) begin // RULE3
                n.busy = 1'b0;
                n.command[`CMD_FLG_BIT] = 1'b0; // RULE2
                if (s.command[`CMD_OPCH_MSB:`CMD_OPCH_LSB] == `SET_TIMER_OPCH) begin
                    n.valid[set_num] = s.tcmd[`TW_VALID_BIT]; // RULE11 RULE12 RULE13
                    n.restart[set_num] = s.tcmd[`TW_RESTART_BIT]; // RULE10 RULE12
                    if (s.tcmd[`TW_VALID_BIT]) begin
                        we_i = 1'b1; // RULE17
                        we_c = 1'b1;
                        widx = s.base[EW+1:2] + EW'(set_num);
                        wi_d = s.tcmd[`TW_PERIOD_MSB:0];
                        wc_d = s.tcmd[`TW_PERIOD_MSB:0];
                    end
                    n.scan_pend = 1'b0; // RULE22
                    n.scan = SC_IDLE;
                    n.ptr = '0;
                end
            end else begin
                n.lat_cnt = s.lat_cnt + 7'h01;
            end
        end else if (!host_mem) begin
            case (s.scan) // RULE6
                SC_IDLE: begin
                    if (s.scan_pend) begin
                        n.scan_pend = 1'b0;
                        n.scan = SC_RUN;
                        n.ptr = '0; // RULE24
                    end
                end
                SC_RUN: begin
                    if (s.valid[tidx]) begin
                        we_c = 1'b1; // RULE21
                        widx = ent;
                        wc_d = cur_v - 16'h0001; // RULE14
                        if (cur_v == 16'h0001) begin
                            n.events[tidx] = 1'b1; // RULE21
                            if (s.restart[tidx]) begin
                                wc_d = init_mem[ent];
                            end else begin
                                n.valid[tidx] = 1'b0;
                            end
                        end
                    end
                    n.ptr = s.ptr + 16'h0001; // RULE24 RULE9
                    if (s.ptr == 16'(NUM_TIMERS - 1)) begin // RULE4
                        n.scan = SC_DONE;
                    end
                end
                SC_DONE: begin
                    n.tcnt = s.tcnt + 32'h0000_0001; // RULE16
                    n.scan = SC_IDLE;
                end
                default: n.scan = SC_IDLE;
            endcase
        end

        // Soft reset is honoured even while a command is running
        if (bus.wr && bus.addr == `OFF_COMMAND && bus.wdata[`CMD_RST_BIT]) begin
            n.command = '0; // RULE1
            n.busy = 1'b0;
            n.valid = '0;
            n.restart = '0;
            n.ptr = '0;
            n.scan = SC_IDLE;
            n.scan_pend = 1'b0;
            we_i = 1'b0;
            we_c = 1'b0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            s <= '{scan: SC_IDLE, default: '0};
        end else begin
            s <= n;
        end
    end

    // Table entries carry no reset; the set-timer command initialises them
    always_ff @(posedge core_clk) begin
        if (we_i) begin
            init_mem[widx] <= wi_d;
        end
        if (we_c) begin
            cur_mem[widx] <= wc_d;
        end
    end

    assign bus.rdata = s.rdata;
    assign bus.rvalid = s.rvalid;
    assign bus.irq = s.cfg_w[`CFG_GMASK_BIT] & (|(s.events & s.enables)); // RULE19
    assign scan_active = (s.scan != SC_IDLE);
    assign tick_total = s.tcnt;
endmodule

// *** design/timer_table_host.sv ***
// Host end: turns user requests into register sequences on the link
`timescale 1ns/1ps
`include "timer_engine_cfg.svh"
module timer_table_host
    import timer_engine_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst,
    coproc_link_if.host bus,
    input wire logic req,
    input wire logic [2:0] op,
    input wire logic [31:0] arg,
    output logic ready,
    output logic done,
    output logic irq
);
    host_state_s s;
    host_state_s n;

    always_comb begin
        n = s;
        n.wr = 1'b0;
        n.rd = 1'b0;
        n.done = 1'b0;
        case (s.st)
            H_IDLE: begin
                if (req) begin
                    n.op = host_op_e'(op);
                    n.arg = arg;
                    n.step = '0;
                    n.st = H_WRITE;
                end
            end
            H_WRITE: begin
                n.wr = 1'b1;
                n.step = s.step + 2'h1;
                n.st = H_IDLE;
                n.done = 1'b1;
                case (s.op)
                    OP_SETUP: begin
                        if (s.step == 2'h0) begin
                            n.addr = `OFF_BASE;
                            n.wdata = s.arg[15:0] & `ALIGN_MASK; // RULE8 RULE7
                            n.st = H_WRITE;
                            n.done = 1'b0;
                        end else begin
                            n.addr = `OFF_ENABLES;
                            n.wdata = s.arg[31:16];
                        end
                    end
                    OP_CONFIG: begin
                        n.addr = `OFF_CONFIG;
                        n.wdata = s.arg[15:0];
                    end
                    OP_SET_TIMER: begin
                        n.done = 1'b0;
                        n.st = H_WRITE;
                        if (s.step == 2'h0) begin
                            n.addr = `OFF_CMD_HI; // RULE12 RULE13 RULE15
                            n.wdata = {s.arg[`TW_VALID_BIT], s.arg[`TW_RESTART_BIT], 10'h000,
                                       s.arg[`TW_NUM_MSB:`TW_NUM_LSB]};
                        end else if (s.step == 2'h1) begin
                            n.addr = `OFF_CMD_LO;
                            n.wdata = s.arg[`TW_PERIOD_MSB:0];
                        end else begin
                            n.addr = `OFF_COMMAND;
                            n.wdata = `CMD_SET_TIMER; // RULE20 RULE23
                            n.st = H_POLL;
                        end
                    end
                    OP_ACK: begin
                        n.addr = `OFF_EVENTS;
                        n.wdata = s.arg[15:0];
                    end
                    OP_RESET: begin
                        n.addr = `OFF_COMMAND;
                        n.wdata = `CMD_SOFT_RESET; // RULE1
                        n.st = H_POLL;
                        n.done = 1'b0;
                    end
                    default: n.wr = 1'b0;
                endcase
            end
            H_POLL: begin
                n.rd = 1'b1;
                n.addr = `OFF_COMMAND;
                n.st = H_WAIT;
            end
            H_WAIT: begin
                // Next command only once the semaphore has dropped
                if (bus.rvalid) begin
                    if (bus.rdata[`CMD_FLG_BIT]) begin // RULE23
                        n.st = H_POLL;
                    end else begin
                        n.st = H_IDLE;
                        n.done = 1'b1;
                    end
                end
            end
            default: n.st = H_IDLE;
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            s <= '{st: H_IDLE, op: OP_SETUP, default: '0};
        end else begin
            s <= n;
        end
    end

    assign bus.addr = s.addr;
    assign bus.wr = s.wr;
    assign bus.rd = s.rd;
    assign bus.wdata = s.wdata;
    assign ready = (s.st == H_IDLE);
    assign done = s.done;
    assign irq = bus.irq;
endmodule

// *** sim/timer_link_checker.sv ***
// Assertions on the register link between host and timer engine
`timescale 1ns/1ps
`include "timer_engine_cfg.svh"
module timer_link_checker
    import timer_engine_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [8:0] addr,
    input wire logic wr,
    input wire logic rd,
    input wire logic [15:0] wdata,
    input wire logic [15:0] rdata,
    input wire logic rvalid,
    input wire logic irq
);
    logic last_cmd_rd_reg;
    logic [15:0] cmd_val_reg;
    logic [15:0] cfg_val_reg;
    logic [15:0] en_val_reg;
    logic [7:0] lat_reg;

    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);

    // Shadows of what the host wrote, so the device answers can be judged
    always_ff @(posedge core_clk) begin
        if (rst) begin
            last_cmd_rd_reg <= 1'b0;
            cmd_val_reg <= 16'h0000;
            cfg_val_reg <= 16'h0000;
            en_val_reg <= 16'h0000;
            lat_reg <= 8'hFF;
        end else begin
            if (rd) begin
                last_cmd_rd_reg <= (addr == `OFF_COMMAND);
            end
            if (wr && addr == `OFF_COMMAND) begin
                cmd_val_reg <= wdata;
                lat_reg <= 8'h00;
            end else if (lat_reg != 8'hFF) begin
                lat_reg <= lat_reg + 8'h01;
            end
            if (wr && addr == `OFF_CONFIG) begin
                cfg_val_reg <= wdata;
            end
            if (wr && addr == `OFF_ENABLES) begin
                en_val_reg <= wdata;
            end
        end
    end

    sequence set_write;
        wr && addr == `OFF_COMMAND && wdata == `CMD_SET_TIMER;
    endsequence
    sequence soft_write;
        wr && addr == `OFF_COMMAND && wdata == `CMD_SOFT_RESET;
    endsequence
    sequence cmd_read;
        rd && addr == `OFF_COMMAND;
    endsequence

    chk_read_answer: assert property (rd |=> rvalid)
        else $error("read not answered next cycle");
    chk_rvalid_cause: assert property (rvalid |-> $past(rd))
        else $error("read answer without a read");
    chk_rdata_hold: assert property (!rvalid |-> $stable(rdata))
        else $error("read data moved without a read");
    chk_soft_reset_zero: assert property (soft_write ##[1:2] cmd_read |=> rdata == 16'h0000)
        else $error("command register not zero after soft reset");
    chk_busy_readback: assert property (set_write ##1 cmd_read |=> rdata == `CMD_SET_TIMER)
        else $error("busy command register lost its value");
    chk_done_value: assert property (rvalid && last_cmd_rd_reg && cmd_val_reg != `CMD_SOFT_RESET
        |-> rdata[15:1] == cmd_val_reg[15:1])
        else $error("command register bits other than the flag changed");
    chk_latency_bound: assert property (rvalid && last_cmd_rd_reg && rdata[0] |-> lat_reg <= 8'd122)
        else $error("command still busy past its latency bound");
    chk_irq_gate: assert property (irq |-> cfg_val_reg[`CFG_GMASK_BIT] && en_val_reg != 16'h0000)
        else $error("interrupt without global mask or enables");
    chk_ack_clear: assert property (wr && addr == `OFF_EVENTS && wdata == 16'hFFFF |=> !irq)
        else $error("interrupt stayed after clearing all events");
endmodule

// *** sim/microcoded_timer_table_engine_bench.sv ***
// Self-checking bench: host end and timer engine joined over the link
`timescale 1ns/1ps
`include "timer_engine_cfg.svh"
`define CHECK(a, b) begin total_checks++; if ((a) !== (b)) begin bad_count++; \
    $display("Error at %0t: got %h expected %h", $time, (a), (b)); end end
module microcoded_timer_table_engine_bench
    import timer_engine_pkg::*;
;
    logic core_clk = 1'b0;
    logic rst;
    logic req;
    logic [2:0] op;
    logic [31:0] arg;
    logic ready;
    logic done;
    logic irq_host;
    logic scan_active;
    logic [31:0] tick_total;
    logic last_cmd_rd = 1'b0;
    logic [15:0] cmd_reads[$];
    int bad_count = 0;
    int total_checks = 0;
    int cycles = 0;
    int tick_gap;
    int scan_cycles;

    coproc_link_if coproc_link_if_inst();
    timer_table_engine timer_table_engine_inst(.core_clk(core_clk), .rst(rst),
        .bus(coproc_link_if_inst.device), .scan_active(scan_active), .tick_total(tick_total));
    timer_table_host timer_table_host_inst(.core_clk(core_clk), .rst(rst),
        .bus(coproc_link_if_inst.host), .req(req), .op(op), .arg(arg), .ready(ready),
        .done(done), .irq(irq_host));
    timer_link_checker timer_link_checker_inst(.core_clk(core_clk), .rst(rst),
        .addr(coproc_link_if_inst.addr), .wr(coproc_link_if_inst.wr),
        .rd(coproc_link_if_inst.rd), .wdata(coproc_link_if_inst.wdata),
        .rdata(coproc_link_if_inst.rdata), .rvalid(coproc_link_if_inst.rvalid),
        .irq(coproc_link_if_inst.irq));

    always #2 core_clk = ~core_clk;

    // Collect every answer to a command register read, and cut hangs short
    always @(posedge core_clk) begin
        if (coproc_link_if_inst.rd) begin
            last_cmd_rd <= (coproc_link_if_inst.addr == `OFF_COMMAND);
        end
        if (coproc_link_if_inst.rvalid && last_cmd_rd) begin
            cmd_reads.push_back(coproc_link_if_inst.rdata);
        end
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            bad_count++;
            $display("Error at %0t: run did not finish", $time);
            complete_run();
        end
    end

    task automatic complete_run();
        $display("Checks %0d, errors %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic run_op(input host_op_e o, input logic [31:0] a);
        int n;
        n = 0;
        @(posedge core_clk);
        req <= 1'b1;
        op <= o;
        arg <= a;
        @(posedge core_clk);
        req <= 1'b0;
        while (done !== 1'b1 && n < 400) begin
            @(posedge core_clk);
            #1;
            n++;
        end
        `CHECK(done, 1'b1)
        // Done rises with the last write strobe, or one cycle after the poll answer; a final write lands one edge later
        @(posedge core_clk);
        #1;
    endtask

    // Waits for the tick count to move; gap counts from 20 cycles after the last move
    task automatic wait_tick();
        logic [31:0] t;
        t = tick_total;
        tick_gap = 0;
        scan_cycles = 0;
        while (tick_total === t && tick_gap < 3000) begin
            @(posedge core_clk);
            #1;
            tick_gap++;
            if (scan_active === 1'b1) begin
                scan_cycles++;
            end
        end
        `CHECK(tick_total !== t, 1'b1)
        repeat (20) @(posedge core_clk);
        #1;
    endtask

    task automatic t_set_timer(input logic [31:0] w);
        cmd_reads.delete();
        run_op(OP_SET_TIMER, w);
        `CHECK(cmd_reads[0], 16'h0851)
        `CHECK(cmd_reads[cmd_reads.size() - 1], 16'h0850)
    endtask

    // Timer 0 restarts every 2 ticks, timer 1 fires once after 1 tick
    task automatic t_expiry();
        run_op(OP_SETUP, 32'h0003_0000);
        t_set_timer(32'hC000_0002);
        t_set_timer(32'h8001_0001);
        run_op(OP_CONFIG, 32'h0000_C000);
        wait_tick();
        `CHECK(tick_total, 32'h0000_0001)
        `CHECK(irq_host, 1'b1)
        run_op(OP_ACK, 32'h0000_FFFF);
        `CHECK(irq_host, 1'b0)
        wait_tick();
        `CHECK(irq_host, 1'b1)
        run_op(OP_ACK, 32'h0000_FFFF);
        wait_tick();
        `CHECK(irq_host, 1'b0)
        wait_tick();
        `CHECK(tick_gap, 1004)
        `CHECK(scan_cycles, 17)
        `CHECK(irq_host, 1'b1)
        `CHECK(tick_total, 32'h0000_0004)
        run_op(OP_ACK, 32'h0000_FFFF);
    endtask

    // Soft reset clears the valid map, ticks keep counting
    task automatic t_soft_reset();
        logic [31:0] t;
        cmd_reads.delete();
        run_op(OP_RESET, 32'h0000_0000);
        `CHECK(cmd_reads[0], 16'h0000)
        t = tick_total;
        wait_tick();
        wait_tick();
        `CHECK(irq_host, 1'b0)
        `CHECK(tick_total, t + 32'h0000_0002)
    endtask

    // Event held back by the global mask until it is opened; tick of two units
    task automatic t_mask();
        run_op(OP_CONFIG, 32'h0000_8001);
        t_set_timer(32'h8001_0001);
        wait_tick();
        `CHECK(irq_host, 1'b0)
        run_op(OP_CONFIG, 32'h0000_C001);
        `CHECK(irq_host, 1'b1)
        run_op(OP_ACK, 32'h0000_0002);
        `CHECK(irq_host, 1'b0)
        wait_tick();
        wait_tick();
        `CHECK(tick_gap, 2028)
    endtask

    initial begin
        rst = 1'b1;
        req = 1'b0;
        op = 3'h0;
        arg = 32'h0000_0000;
        repeat (6) @(posedge core_clk);
        rst <= 1'b0;
        t_expiry();
        t_soft_reset();
        t_mask();
        complete_run();
    end
endmodule
